// File: bench/async_event_counter_16bit_properties.sv
`include "event_counter_defs.svh"

module async_event_counter_16bit_properties
   import event_counter_pkg::*;
#(
   parameter int PRESCALER_W = `PRESCALER_W
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [`EC_ADDR_W-1:0] addr_i,
   input wire logic [`EC_DATA_W-1:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [`EC_DATA_W-1:0] rd_data_o,
   input wire logic event_gate_pin_i,
   input wire logic lower_event_pin_i,
   input wire logic irq_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic en_shadow_reg;
   logic mapped;
   logic wr_cs;
   logic rd_cs;
   assign mapped = addr_i inside {16'hff90, 16'hff91, 16'hff95, 16'hff96, 16'hff97, 16'hfff4, 16'hfff7};
   assign wr_cs = wr_i && addr_i == `OFS_CONTROL_STATUS;
   assign rd_cs = rd_i && addr_i == `OFS_CONTROL_STATUS;

   // Copy of the interrupt enable bit
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         en_shadow_reg <= 1'b0;
      end else if (wr_i && addr_i == `OFS_IRQ_ENABLE) begin
         en_shadow_reg <= wr_data_i[0];
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   ////////////////////////////////////////////////////////////
   rd_idle_zero_a: assert property (!$past(rd_i) |-> rd_data_o == 8'h00)
      else $error("read data not idle");
   unmapped_read_a: assert property (rd_i && !mapped |=> rd_data_o == 8'h00)
      else $error("unmapped read not zero");
   reserved_zero_a: assert property (rd_cs |=> rd_data_o[6:5] == 2'h0)
      else $error("reserved bits not zero");
   status_back_a: assert property (wr_cs ##1 !wr_i ##1 rd_cs |=>
      rd_data_o[4:0] == $past(wr_data_i[4:0], 3)) else $error("control bits lost");
   select_back_a: assert property (wr_i && addr_i == `OFS_CLOCK_CONTROL ##1 !wr_i ##1
      rd_i && addr_i == `OFS_CLOCK_CONTROL |=> rd_data_o[5:4] == $past(wr_data_i[5:4], 3))
      else $error("clock select lost");
   pwm_back_a: assert property (wr_i && addr_i == `OFS_EDGE_SELECT ##1 !wr_i ##1
      rd_i && addr_i == `OFS_EDGE_SELECT |=> rd_data_o[1] == $past(wr_data_i[1], 3))
      else $error("pwm enable lost");
   irq_en_back_a: assert property (rd_i && addr_i == `OFS_IRQ_ENABLE |=>
      rd_data_o[0] == $past(en_shadow_reg)) else $error("irq enable readback wrong");
   lower_held_a: assert property (wr_cs && !wr_data_i[0] ##1 !wr_i ##1
      rd_i && addr_i == `OFS_LOWER_COUNT |=> rd_data_o == 8'h00) else $error("lower not held");
   upper_held_a: assert property (wr_cs && !wr_data_i[1] ##1 !wr_i ##1
      rd_i && addr_i == `OFS_UPPER_COUNT |=> rd_data_o == 8'h00) else $error("upper not held");
   irq_gated_a: assert property (irq_o |-> $past(en_shadow_reg))
      else $error("irq while disabled");
endmodule : async_event_counter_16bit_properties

bind async_event_counter_16bit async_event_counter_16bit_properties #(.PRESCALER_W(PRESCALER_W)) i_props (
   .mclk_i, .rst_n_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o,
   .event_gate_pin_i, .lower_event_pin_i, .irq_o);

// File: bench/async_event_counter_16bit_test.sv
`include "event_counter_defs.svh"

module async_event_counter_16bit_test
   import event_counter_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [7:0] wr_data = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic gate = 1'b1;
   logic ev_pin = 1'b0;
   logic [2:0] pin_cnt = 3'h0;
   logic [7:0] rd_data;
   logic irq;
   int failures = 0;
   int cmp_count = 0;
   logic [7:0] rate_tab [4] = '{8'h0a, 8'h14, 8'h05, 8'h04};
   logic [7:0] up_cfg [4] = '{8'h0f, 8'h07, 8'h0d, 8'h1f};
   logic [7:0] up_exp [4] = '{8'h01, 8'h00, 8'h00, 8'h00};

   async_event_counter_16bit i_dut (.mclk_i(mclk), .rst_n_i(rst_n), .addr_i(addr), .wr_data_i(wr_data),
      .wr_i(wr), .rd_i(rd), .rd_data_o(rd_data), .event_gate_pin_i(gate),
      .lower_event_pin_i(ev_pin), .irq_o(irq));

   initial begin
      forever #2 mclk = ~mclk;
   end

   // Event pin toggles every 5 cycles: 4 rising edges per 40 cycles
   always @(posedge mclk) begin
      pin_cnt <= (pin_cnt == 3'h4) ? 3'h0 : pin_cnt + 3'h1;
      if (pin_cnt == 3'h4) begin
         ev_pin <= ~ev_pin;
      end
   end

   ////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wr_data <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 d = rd_data;
   endtask : rd_reg

   task automatic measure(input logic [7:0] exp);
      logic [7:0] a;
      logic [7:0] b;
      logic [7:0] d;
      rd_reg(`OFS_LOWER_COUNT, a);
      repeat (38) @(posedge mclk);
      rd_reg(`OFS_LOWER_COUNT, b);
      d = b - a;
      check({8'h00, d}, {8'h00, exp});
   endtask : measure

   task automatic irq_after(input logic [15:0] a, input logic [7:0] d, input logic exp);
      wr_reg(a, d);
      repeat (2) @(posedge mclk);
      #1 check({15'h0000, irq}, {15'h0000, exp});
   endtask : irq_after

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : conclude

   ////////////////////////////////////////////////////////////
   task automatic t_defaults();
      logic [15:0] adr [8] = '{16'hff90, 16'hff91, 16'hff95, 16'hff96, 16'hff97, 16'hfff4, 16'hfff7, 16'hff00};
      logic [7:0] v;
      foreach (adr[i]) begin
         rd_reg(adr[i], v);
         check({8'h00, v}, 16'h0000);
      end
   endtask : t_defaults

   task automatic t_readback();
      logic [7:0] v;
      wr_reg(`OFS_CONTROL_STATUS, 8'h9c);
      rd_reg(`OFS_CONTROL_STATUS, v);
      check({8'h00, v}, 16'h001c);
      wr_reg(`OFS_EDGE_SELECT, 8'h02);
      rd_reg(`OFS_EDGE_SELECT, v);
      check({8'h00, v}, 16'h0002);
      for (int i = 3; i >= 0; i--) begin
         wr_reg(`OFS_CLOCK_CONTROL, 8'(i << 4));
         rd_reg(`OFS_CLOCK_CONTROL, v);
         check({8'h00, v}, 16'(i << 4));
      end
      wr_reg(`OFS_IRQ_FLAG, 8'h01);
      rd_reg(`OFS_IRQ_FLAG, v);
      check({8'h00, v}, 16'h0000);
      wr_reg(`OFS_EDGE_SELECT, 8'h00);
   endtask : t_readback

   task automatic t_rates();
      logic [7:0] v;
      wr_reg(`OFS_CONTROL_STATUS, 8'h0f);
      for (int i = 0; i < 4; i++) begin
         wr_reg(`OFS_CLOCK_CONTROL, 8'(i << 4));
         measure(rate_tab[i]);
      end
      wr_reg(`OFS_CLOCK_CONTROL, 8'h00);
      gate <= 1'b0;
      repeat (4) @(posedge mclk);
      measure(8'h00);
      wr_reg(`OFS_EDGE_SELECT, 8'h02);
      measure(8'h0a);
      wr_reg(`OFS_EDGE_SELECT, 8'h00);
      gate <= 1'b1;
      wr_reg(`OFS_CONTROL_STATUS, 8'h0b);
      measure(8'h00);
      wr_reg(`OFS_CONTROL_STATUS, 8'h0e);
      rd_reg(`OFS_LOWER_COUNT, v);
      check({8'h00, v}, 16'h0000);
   endtask : t_rates

   task automatic t_upper();
      logic [7:0] v;
      wr_reg(`OFS_CLOCK_CONTROL, 8'h10);
      for (int i = 0; i < 4; i++) begin
         wr_reg(`OFS_CONTROL_STATUS, 8'h00);
         rd_reg(`OFS_UPPER_COUNT, v);
         check({8'h00, v}, 16'h0000);
         wr_reg(`OFS_CONTROL_STATUS, up_cfg[i]);
         repeat (600) @(posedge mclk);
         rd_reg(`OFS_UPPER_COUNT, v);
         check({8'h00, v}, {8'h00, up_exp[i]});
      end
   endtask : t_upper

   task automatic t_overflow();
      logic [7:0] v;
      int n = 0;
      wr_reg(`OFS_IRQ_ENABLE, 8'h01);
      wr_reg(`OFS_CONTROL_STATUS, 8'h00);
      wr_reg(`OFS_CONTROL_STATUS, 8'h0f);
      while (irq !== 1'b1 && n < 140000) begin
         @(posedge mclk);
         #1;
         n++;
      end
      check({15'h0000, n >= 131066 && n <= 131080}, 16'h0001);
      rd_reg(`OFS_UPPER_COUNT, v);
      check({8'h00, v}, 16'h0000);
      rd_reg(`OFS_IRQ_FLAG, v);
      check({8'h00, v}, 16'h0001);
      // A zero write without a prior read of the flag must not clear it
      wr_reg(`OFS_CONTROL_STATUS, 8'h0f);
      rd_reg(`OFS_CONTROL_STATUS, v);
      check({8'h00, v}, 16'h008f);
      wr_reg(`OFS_CONTROL_STATUS, 8'h8f);
      rd_reg(`OFS_CONTROL_STATUS, v);
      check({8'h00, v}, 16'h008f);
      wr_reg(`OFS_CONTROL_STATUS, 8'h0f);
      rd_reg(`OFS_CONTROL_STATUS, v);
      check({8'h00, v}, 16'h000f);
      irq_after(`OFS_IRQ_ENABLE, 8'h00, 1'b0);
      irq_after(`OFS_IRQ_ENABLE, 8'h01, 1'b1);
      irq_after(`OFS_IRQ_FLAG, 8'h01, 1'b1);
      irq_after(`OFS_IRQ_FLAG, 8'h00, 1'b0);
   endtask : t_overflow

   ////////////////////////////////////////////////////////////
   initial begin
      repeat (200000) @(posedge mclk);
      failures++;
      conclude();
   end

   initial begin
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      t_defaults();
      t_readback();
      t_rates();
      t_upper();
      t_overflow();
      conclude();
   end
endmodule : async_event_counter_16bit_test

// File: inc/event_counter_defs.svh
`ifndef EVENT_COUNTER_DEFS_SVH
`define EVENT_COUNTER_DEFS_SVH

// Register bus widths
`define EC_ADDR_W 16
`define EC_DATA_W 8

// Register offsets
`define OFS_EDGE_SELECT 16'hff90
`define OFS_CLOCK_CONTROL 16'hff91
`define OFS_CONTROL_STATUS 16'hff95
`define OFS_UPPER_COUNT 16'hff96
`define OFS_LOWER_COUNT 16'hff97
`define OFS_IRQ_ENABLE 16'hfff4
`define OFS_IRQ_FLAG 16'hfff7

// Field positions
`define CLKCTL_SEL_HI 5
`define CLKCTL_SEL_LO 4
`define EDGE_PWM_BIT 1
`define IRQ_BIT 0

// Lower clock select encodings
`define SEL_PHI4 2'h0
`define SEL_PHI2 2'h1
`define SEL_PHI8 2'h2
`define SEL_PIN 2'h3

// Reset values
`define CS_RESET 8'h00
`define CLKCTL_RESET 8'h00
`define EDGE_RESET 8'h00
`define COUNT_RESET 8'h00
`define RD_ZERO 8'h00

// Timing at the nominal 10 MHz system clock
`define PRESCALER_W 13
`define PHI4_TICK_NS 400
`define OVF_PERIOD_NS 26214400
`define TOTAL_SPAN (`OVF_PERIOD_NS / `PHI4_TICK_NS)

`endif

// File: inc/event_counter_pkg.sv
package event_counter_pkg;
   `include "event_counter_defs.svh"

   localparam int TOTAL_W = $clog2(`TOTAL_SPAN);
   localparam int HALF_W = TOTAL_W / 2;

   typedef logic [HALF_W-1:0] half_t;

   typedef struct packed {
      logic phi2;
      logic phi4;
      logic phi8;
   } tick_s;

   typedef struct packed {
      logic ovf;
      logic [1:0] rsvd;
      logic pairing;
      logic upper_en;
      logic lower_en;
      logic upper_run;
      logic lower_run;
   } ctrl_status_s;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [`EC_ADDR_W-1:0] addr;
      logic [`EC_DATA_W-1:0] data;
   } bus_req_s;
endpackage : event_counter_pkg

// File: rtl/async_event_counter_16bit.sv
// Our own choice: the strobed register port.
`include "event_counter_defs.svh"

module async_event_counter_16bit
   import event_counter_pkg::*;
#(
   parameter int PRESCALER_W = `PRESCALER_W
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [`EC_ADDR_W-1:0] addr_i,
   input wire logic [`EC_DATA_W-1:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [`EC_DATA_W-1:0] rd_data_o,
   input wire logic event_gate_pin_i,
   input wire logic lower_event_pin_i,
   output logic irq_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   bus_req_s req;
   tick_s tick;

   ctrl_status_s ctrl_status_reg;
   ctrl_status_s ctrl_status_next;
   logic [`EC_DATA_W-1:0] clock_control_reg;
   logic [`EC_DATA_W-1:0] edge_select_reg;
   logic counter_irq_enable_reg;
   logic counter_irq_flag_reg;
   logic counter_irq_flag_next;
   logic upper_overflow_flag_next;
   logic ovf_armed_reg;
   logic ovf_armed_next;
   logic lower_pin_reg;
   half_t upper_event_count_reg;
   half_t upper_event_count_next;
   half_t lower_event_count_reg;
   half_t lower_event_count_next;
   logic [`EC_DATA_W-1:0] rd_data_reg;
   logic [`EC_DATA_W-1:0] rd_data_next;
   logic irq_reg;

   logic sel_edge;
   logic sel_clkctl;
   logic sel_cs;
   logic sel_upper;
   logic sel_lower;
   logic sel_ien;
   logic sel_iflag;
   logic wr_edge;
   logic wr_clkctl;
   logic wr_cs;
   logic wr_ien;
   logic wr_iflag;
   logic rd_cs;

   logic [1:0] lower_clock_select;
   logic lower_clock_select_hi;
   logic lower_clock_select_lo;
   logic counter_pwm_enable;
   logic channel_pairing_select;
   logic upper_count_enable;
   logic lower_count_enable;
   logic upper_reset_release;
   logic lower_reset_release;
   logic upper_overflow_flag;

   logic pin_rise;
   logic lower_src_tick;
   logic event_gate;
   logic lower_advance;
   logic lower_wrap;
   logic upper_src_tick;
   logic upper_advance;
   logic upper_wrap;
   logic ovf_clear_req;
   logic iflag_clear_req;
   ctrl_status_s cs_wr_view;
   ctrl_status_s cs_rd_view;

   ////////////////////////////////////////////////////////////////////////////
   // Bus request bundle
   assign req.wr = wr_i;
   assign req.rd = rd_i;
   assign req.addr = addr_i;
   assign req.data = wr_data_i;

   ////////////////////////////////////////////////////////////////////////////
   // Address decode
   assign sel_edge = (req.addr == `OFS_EDGE_SELECT);
   assign sel_clkctl = (req.addr == `OFS_CLOCK_CONTROL);
   assign sel_cs = (req.addr == `OFS_CONTROL_STATUS);
   assign sel_upper = (req.addr == `OFS_UPPER_COUNT);
   assign sel_lower = (req.addr == `OFS_LOWER_COUNT);
   assign sel_ien = (req.addr == `OFS_IRQ_ENABLE);
   assign sel_iflag = (req.addr == `OFS_IRQ_FLAG);

   assign wr_edge = req.wr & sel_edge;
   assign wr_clkctl = req.wr & sel_clkctl;
   assign wr_cs = req.wr & sel_cs;
   assign wr_ien = req.wr & sel_ien;
   assign wr_iflag = req.wr & sel_iflag;
   assign rd_cs = req.rd & sel_cs;

   assign cs_wr_view = ctrl_status_s'(req.data);

   ////////////////////////////////////////////////////////////////////////////
   // Control fields
   assign lower_clock_select_hi = clock_control_reg[`CLKCTL_SEL_HI];
   assign lower_clock_select_lo = clock_control_reg[`CLKCTL_SEL_LO];
   assign lower_clock_select = {lower_clock_select_hi, lower_clock_select_lo};
   assign counter_pwm_enable = edge_select_reg[`EDGE_PWM_BIT];
   assign channel_pairing_select = ctrl_status_reg.pairing;
   assign upper_count_enable = ctrl_status_reg.upper_en;
   assign lower_count_enable = ctrl_status_reg.lower_en;
   assign upper_reset_release = ctrl_status_reg.upper_run;
   assign lower_reset_release = ctrl_status_reg.lower_run;
   assign upper_overflow_flag = ctrl_status_reg.ovf;

   ////////////////////////////////////////////////////////////////////////////
   // Prescaler
   event_prescaler #(
      .WIDTH(PRESCALER_W)
   ) u_prescaler (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .tick_o(tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Lower clock source
   assign pin_rise = lower_event_pin_i & ~lower_pin_reg;

   assign lower_src_tick = (lower_clock_select == `SEL_PHI4) ? tick.phi4 :
                           (lower_clock_select == `SEL_PHI2) ? tick.phi2 :
                           (lower_clock_select == `SEL_PHI8) ? tick.phi8 :
                           pin_rise;

   ////////////////////////////////////////////////////////////////////////////
   // Event gate
   assign event_gate = counter_pwm_enable ? 1'b1 : event_gate_pin_i;

   ////////////////////////////////////////////////////////////////////////////
   // Lower counter
   assign lower_advance = lower_reset_release & lower_count_enable
                          & event_gate & lower_src_tick;
   assign lower_wrap = lower_advance & (&lower_event_count_reg);

   assign lower_event_count_next = !lower_reset_release ? half_t'(`COUNT_RESET) :
                                   lower_advance ? lower_event_count_reg + half_t'(1) :
                                   lower_event_count_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Upper counter
   assign upper_src_tick = ~channel_pairing_select & lower_wrap;
   assign upper_advance = upper_reset_release & upper_count_enable
                          & event_gate & upper_src_tick;
   assign upper_wrap = upper_advance & (&upper_event_count_reg);

   assign upper_event_count_next = !upper_reset_release ? half_t'(`COUNT_RESET) :
                                   upper_advance ? upper_event_count_reg + half_t'(1) :
                                   upper_event_count_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Overflow flag, armed by reading it as one
   assign ovf_armed_next = rd_cs ? upper_overflow_flag :
                           wr_cs ? 1'b0 :
                           ovf_armed_reg;
   assign ovf_clear_req = wr_cs & ~cs_wr_view.ovf & ovf_armed_reg;
   assign upper_overflow_flag_next = upper_wrap ? 1'b1 :
                                     ovf_clear_req ? 1'b0 :
                                     upper_overflow_flag;

   always_comb begin
      ctrl_status_next = ctrl_status_reg;
      if (wr_cs) begin
         ctrl_status_next = cs_wr_view;
      end
      ctrl_status_next.rsvd = 2'h0;
      ctrl_status_next.ovf = upper_overflow_flag_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt request flag
   assign iflag_clear_req = wr_iflag & ~req.data[`IRQ_BIT];
   assign counter_irq_flag_next = upper_wrap ? 1'b1 :
                                  iflag_clear_req ? 1'b0 :
                                  counter_irq_flag_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Read data
   assign cs_rd_view = ctrl_status_reg;

   assign rd_data_next = !req.rd ? `RD_ZERO :
                         sel_edge ? edge_select_reg :
                         sel_clkctl ? clock_control_reg :
                         sel_cs ? cs_rd_view :
                         sel_upper ? upper_event_count_reg :
                         sel_lower ? lower_event_count_reg :
                         sel_ien ? (`RD_ZERO | counter_irq_enable_reg) :
                         sel_iflag ? (`RD_ZERO | counter_irq_flag_reg) :
                         `RD_ZERO;

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         edge_select_reg <= `EDGE_RESET;
         clock_control_reg <= `CLKCTL_RESET;
         counter_irq_enable_reg <= 1'b0;
      end else begin
         if (wr_edge) begin
            edge_select_reg <= req.data;
         end
         if (wr_clkctl) begin
            clock_control_reg <= req.data;
         end
         if (wr_ien) begin
            counter_irq_enable_reg <= req.data[`IRQ_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status and flags
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_status_reg <= ctrl_status_s'(`CS_RESET);
         ovf_armed_reg <= 1'b0;
         counter_irq_flag_reg <= 1'b0;
      end else begin
         ctrl_status_reg <= ctrl_status_next;
         ovf_armed_reg <= ovf_armed_next;
         counter_irq_flag_reg <= counter_irq_flag_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counters
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lower_event_count_reg <= half_t'(`COUNT_RESET);
         upper_event_count_reg <= half_t'(`COUNT_RESET);
         lower_pin_reg <= 1'b0;
      end else begin
         lower_event_count_reg <= lower_event_count_next;
         upper_event_count_reg <= upper_event_count_next;
         lower_pin_reg <= lower_event_pin_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_data_reg <= `RD_ZERO;
         irq_reg <= 1'b0;
      end else begin
         rd_data_reg <= rd_data_next;
         irq_reg <= counter_irq_flag_reg & counter_irq_enable_reg;
      end
   end

   assign rd_data_o = rd_data_reg;
   assign irq_o = irq_reg;

endmodule : async_event_counter_16bit

// File: rtl/event_prescaler.sv
`include "event_counter_defs.svh"

module event_prescaler
   import event_counter_pkg::*;
#(
   parameter int WIDTH = `PRESCALER_W
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   output tick_s tick_o
);

   logic [WIDTH-1:0] count_reg;
   logic [WIDTH-1:0] count_next;

   ////////////////////////////////////////////////////////////////////////////
   // Free running prescaler
   assign count_next = count_reg + {{(WIDTH-1){1'b0}}, 1'b1};

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count_reg <= '0;
      end else begin
         count_reg <= count_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Divided clock ticks, one cycle wide
   assign tick_o.phi2 = &count_reg[0:0];
   assign tick_o.phi4 = &count_reg[1:0];
   assign tick_o.phi8 = &count_reg[2:0];

endmodule : event_prescaler
